/* eeprom_port_pkg.sv */
// Purpose: constants, frame layout and carriers for the eeprom serial port
// Assumes: 25 MHz aclk, axi4-lite register bus, 32-bit data words
// Notes:   byte offsets are multiples of four; one aligned word each
// Behaviour
// - A rising transfer window arms the port; no frame counts before it.
// - Serial data in is sampled on rising serial clock while window open.
// - First two frame bits are the address, address low bit first.
// - Third bit: one reads the addressed register, zero writes it.
// - Last eight bits carry write data; ignored and zero on reads.
// - The strobe pulse copies the input register into the addressed location.
// - Mode select low ends serial mode and frees the shared pins.
// - On reads the register shifts out on serial data out, on rising edges.
// - Read data shows the stored contents at the moment of the read.
// - Register bit 0 sits at the data low bit position, both directions.
package eeprom_port_pkg;
  // ----------------------------------------------------------------
  // bus geometry and register offsets
  // ----------------------------------------------------------------
  localparam int          AXI_AW     = 4;
  localparam logic [3:0]  OFS_CTRL   = 4'h0;
  localparam logic [3:0]  OFS_STATUS = 4'h4;
  localparam logic [3:0]  OFS_STORE  = 4'h8;
  localparam logic [3:0]  OFS_COUNT  = 4'hC;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_LOCK_POS    = 0;
  localparam int ST_MODE_POS      = 0;
  localparam int ST_ARMED_POS     = 1;
  localparam int ST_PENDING_POS   = 2;
  localparam int ST_PADDR_POS     = 4;
  localparam int ST_SHORT_POS     = 6;
  localparam int ST_FRERR_POS     = 7;
  localparam int CNT_FRAMES_POS   = 0;
  localparam int CNT_COMMITS_POS  = 8;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic        CTRL_LOCK_RST = 1'b0;
  localparam logic [31:0] STORE_RESET   = 32'h0000_0000;
  // ----------------------------------------------------------------
  // frame and timing
  // ----------------------------------------------------------------
  localparam logic [4:0]  FRAME_BITS    = 5'h10;
  localparam logic [4:0]  DATA_FIRST    = 5'h07;
  localparam logic [4:0]  DATA_LAST     = 5'h0E;
  localparam int          ENTRIES       = 4;
  localparam int          CLK_HZ        = 25000000;
  localparam int          STROBE_MIN_MS = 5;
  localparam int          STROBE_MIN_CYC_DEF = (CLK_HZ / 1000) * STROBE_MIN_MS;
  // frame bits in arrival order, first bit at position 0
  typedef struct packed {
    logic [7:0] data;
    logic [4:0] pad;
    logic       rd;
    logic [1:0] addr;
  } frame_t;
  // shared pins of the serial mode
  typedef struct packed {
    logic mode_select;
    logic transfer_window;
    logic program_strobe;
  } link_pins_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HIGH = 2'b10
  } strobe_state_t;
endpackage

/* sync3.sv */
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs are levels from another clock domain or a pin
// Notes:   output moves only when stages two and three agree
`timescale 1ns/1ns
module sync3 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // stage one feeds stage two only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1   <= '0;
      stage2   <= '0;
      stage3   <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          sync_out[i] <= stage3[i];
        end
      end
    end
  end
endmodule

/* eeprom_serial_programming_port.sv */
// Purpose: serial programming and readback port for the configuration store
// Assumes: serial_clk runs only inside frames; pins are set up before its edges
// Notes:   frame word crosses by toggle; store image is quiet while window open
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module eeprom_serial_programming_port #(
  parameter int unsigned STROBE_MIN_CYC = eeprom_port_pkg::STROBE_MIN_CYC_DEF,
  parameter logic [31:0] STORE_INIT     = eeprom_port_pkg::STORE_RESET
) (
  // system
  input  wire logic                               aclk,
  input  wire logic                               aresetn,
  // axi4-lite write address
  input  wire logic [eeprom_port_pkg::AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                               s_axi_awvalid,
  output logic                                    s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]                        s_axi_wdata,
  input  wire logic [3:0]                         s_axi_wstrb,
  input  wire logic                               s_axi_wvalid,
  output logic                                    s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                              s_axi_bresp,
  output logic                                    s_axi_bvalid,
  input  wire logic                               s_axi_bready,
  // axi4-lite read address
  input  wire logic [eeprom_port_pkg::AXI_AW-1:0] s_axi_araddr,
  input  wire logic                               s_axi_arvalid,
  output logic                                    s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                             s_axi_rdata,
  output logic [1:0]                              s_axi_rresp,
  output logic                                    s_axi_rvalid,
  input  wire logic                               s_axi_rready,
  // serial link
  input  wire logic                               serial_clk,
  input  wire logic                               serial_din,
  input  wire eeprom_port_pkg::link_pins_t        link_pins,
  output logic                                    serial_dout,
  output logic                                    serial_dout_oe_n,
  output logic                                    serial_mode
);
  import eeprom_port_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic          link_clr_n;
  logic          link_open;
  logic [4:0]    bit_count;
  frame_t        shift;
  logic [1:0]    rd_addr;
  logic          rd_op;
  logic          frame_toggle;
  logic [31:0]   store_image;
  logic [3:0]    sync_bits;
  logic          mode_active;
  logic          window_s;
  logic          strobe_s;
  logic          toggle_s;
  logic          window_prev;
  logic          toggle_seen;
  logic          armed;
  logic          frame_take;
  logic          pending;
  frame_t        pend;
  logic          short_strobe;
  logic          frame_error;
  logic          commit_lock;
  logic [7:0]    frames;
  logic [7:0]    commits;
  strobe_state_t state;
  logic [23:0]   hi_count;
  logic          strobe_done;
  logic          storage_we;
  logic [7:0]    store [ENTRIES];
  logic          aw_held;
  logic          w_held;
  logic [3:0]    aw_addr;
  logic [31:0]   w_data;
  logic [3:0]    w_strb;
  logic          do_write;
  logic          clr_short;
  logic          clr_frerr;

  // ----------------------------------------------------------------
  // link domain on serial_clk
  // ----------------------------------------------------------------
  // window or mode low holds the link clear; gated pins, so no frame edge may
  // fall near a window transition
  assign link_clr_n = aresetn & link_pins.mode_select & link_pins.transfer_window;
  assign link_open  = link_pins.mode_select & link_pins.transfer_window;

  // bit counter restarts each window and stops at sixteen
  always_ff @(posedge serial_clk or negedge link_clr_n) begin
    if (!link_clr_n) begin
      bit_count <= 5'h00;
    end else if (bit_count != FRAME_BITS) begin
      bit_count <= bit_count + 5'h01;
    end
  end

  // shift register keeps its word after the window so aclk can take it
  always_ff @(posedge serial_clk or negedge aresetn) begin
    if (!aresetn) begin
      shift <= '0;
    end else if (link_open && bit_count != FRAME_BITS) begin
      shift <= {serial_din, shift[15:1]};
    end
  end

  // address and direction are known early so read data can start on time
  always_ff @(posedge serial_clk or negedge link_clr_n) begin
    if (!link_clr_n) begin
      rd_addr <= 2'h0;
      rd_op   <= 1'b0;
    end else begin
      if (bit_count == 5'h00) begin
        rd_addr[0] <= serial_din;
      end
      if (bit_count == 5'h01) begin
        rd_addr[1] <= serial_din;
      end
      if (bit_count == 5'h02) begin
        rd_op <= serial_din;
      end
    end
  end

  // read data out, one bit per edge; zero outside the data slots and after mode exit
  always_ff @(posedge serial_clk or negedge link_clr_n) begin
    if (!link_clr_n) begin
      serial_dout <= 1'b0;
    end else if (rd_op && bit_count >= DATA_FIRST && bit_count <= DATA_LAST) begin
      // store image is stable here: commits wait for a closed window
      serial_dout <= store_image[{rd_addr, 3'(bit_count - DATA_FIRST)}];
    end else begin
      serial_dout <= 1'b0;
    end
  end

  // frame completion event toward aclk
  always_ff @(posedge serial_clk or negedge aresetn) begin
    if (!aresetn) begin
      frame_toggle <= 1'b0;
    end else if (link_open && bit_count == 5'h0F) begin
      frame_toggle <= ~frame_toggle;
    end
  end

  // ----------------------------------------------------------------
  // pin and event crossing into aclk
  // ----------------------------------------------------------------
  sync3 #(
    .WIDTH (4)
  ) u_sync (
    .clk      (aclk),
    .rst_n    (aresetn),
    .async_in ({frame_toggle, link_pins.mode_select,
                link_pins.transfer_window, link_pins.program_strobe}),
    .sync_out (sync_bits)
  );
  assign toggle_s    = sync_bits[3];
  assign mode_active = sync_bits[2];
  assign window_s    = sync_bits[1];
  assign strobe_s    = sync_bits[0];
  assign frame_take  = (toggle_s ^ toggle_seen) & armed & mode_active;

  // edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      window_prev <= 1'b0;
      toggle_seen <= 1'b0;
    end else begin
      window_prev <= window_s;
      toggle_seen <= toggle_s;
    end
  end

  // a frame counts only after a rising window in serial mode
  always_ff @(posedge aclk) begin
    if (!aresetn || !mode_active) begin
      armed <= 1'b0;
    end else if (window_s && !window_prev) begin
      armed <= 1'b1;
    end else if (frame_take) begin
      armed <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // input register and commit
  // ----------------------------------------------------------------
  // the word is held in the link domain until the next window's first edge
  always_ff @(posedge aclk) begin
    if (!aresetn || !mode_active) begin
      pending <= 1'b0;
      pend    <= '0;
    end else if (frame_take) begin
      pending <= ~shift.rd;
      pend    <= shift;
    end else if (storage_we) begin
      pending <= 1'b0;
    end
  end

  // strobe pulse timing; the commit happens as the strobe returns to ground
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state    <= ST_IDLE;
      hi_count <= 24'h000000;
    end else begin
      case (state)
        ST_IDLE: begin
          hi_count <= 24'h000000;
          if (strobe_s) begin
            state <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (!strobe_s) begin
            state <= ST_IDLE;
          end else if (hi_count != 24'hFFFFFF) begin
            hi_count <= hi_count + 24'h000001;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  assign strobe_done = (state == ST_HIGH) && !strobe_s;
  assign storage_we  = strobe_done && pending && !commit_lock && mode_active && !window_s
                       && (32'(hi_count) >= STROBE_MIN_CYC);

  // configuration store, one byte per address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < ENTRIES; i++) begin
        store[i] <= STORE_INIT[8*i +: 8];
      end
    end else if (storage_we) begin
      store[pend.addr] <= pend.data;
    end
  end

  // flat image read by the link; always the live contents
  for (genvar g = 0; g < ENTRIES; g++) begin : g_image
    assign store_image[8*g +: 8] = store[g];
  end

  // sticky error flags; a new event wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      short_strobe <= 1'b0;
      frame_error  <= 1'b0;
    end else begin
      short_strobe <= (short_strobe & ~clr_short)
                      | (strobe_done && pending && !storage_we);
      frame_error  <= (frame_error & ~clr_frerr)
                      | (frame_take && (shift.pad != 5'h00));
    end
  end

  // activity counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frames  <= 8'h00;
      commits <= 8'h00;
    end else begin
      frames  <= frames + {7'h00, frame_take};
      commits <= commits + {7'h00, storage_we};
    end
  end

  // shared pins are handed back once mode select is seen low
  assign serial_mode      = mode_active;
  assign serial_dout_oe_n = ~mode_active;

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held && w_held;
  assign clr_short     = do_write && aw_addr == OFS_STATUS && w_strb[0]
                         && w_data[ST_SHORT_POS];
  assign clr_frerr     = do_write && aw_addr == OFS_STATUS && w_strb[0]
                         && w_data[ST_FRERR_POS];

  // address and data are captured independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else if (do_write) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // control register: lock blocks commits during bench or field use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      commit_lock <= CTRL_LOCK_RST;
    end else if (do_write && aw_addr == OFS_CTRL && w_strb[0]) begin
      commit_lock <= w_data[CTRL_LOCK_POS];
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (aw_addr[1:0] != 2'h0) ? RESP_DECERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read data, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      case (s_axi_araddr)
        OFS_CTRL: begin
          s_axi_rdata[CTRL_LOCK_POS] <= commit_lock;
        end
        OFS_STATUS: begin
          s_axi_rdata[ST_MODE_POS]             <= mode_active;
          s_axi_rdata[ST_ARMED_POS]            <= armed;
          s_axi_rdata[ST_PENDING_POS]          <= pending;
          s_axi_rdata[ST_PADDR_POS +: 2]       <= pend.addr;
          s_axi_rdata[ST_SHORT_POS]            <= short_strobe;
          s_axi_rdata[ST_FRERR_POS]            <= frame_error;
        end
        OFS_STORE: begin
          s_axi_rdata <= store_image;
        end
        OFS_COUNT: begin
          s_axi_rdata[CNT_FRAMES_POS +: 8]  <= frames;
          s_axi_rdata[CNT_COMMITS_POS +: 8] <= commits;
        end
        default: begin
          s_axi_rresp <= RESP_DECERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_commit_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
    storage_we |-> 32'(hi_count) >= STROBE_MIN_CYC && !window_s && !commit_lock)
    else $error("commit without a long enough strobe");
  chk_commit_store: assert property (@(posedge aclk) disable iff (!aresetn)
    storage_we |=> store[$past(pend.addr)] == $past(pend.data))
    else $error("commit did not store the pending word");
  chk_one_commit: assert property (@(posedge aclk) disable iff (!aresetn)
    storage_we |=> !pending ##1 !storage_we)
    else $error("second commit from one frame");
  chk_frame_armed: assert property (@(posedge aclk) disable iff (!aresetn)
    (frame_take && !shift.rd) |=> pending && !armed)
    else $error("write frame not held or port still armed");
  chk_mode_exit: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(mode_active) |=> !armed && !pending && serial_dout_oe_n)
    else $error("serial state kept after mode exit");
  chk_read_noload: assert property (@(posedge aclk) disable iff (!aresetn)
    (frame_take && shift.rd) |=> !pending)
    else $error("read frame left a write pending");
  chk_count_stop: assert property (@(posedge serial_clk) disable iff (!link_clr_n)
    bit_count == FRAME_BITS |=> bit_count == FRAME_BITS)
    else $error("bit counter moved past sixteen");
  chk_dout_quiet: assert property (@(posedge serial_clk) disable iff (!link_clr_n)
    (bit_count > 5'h03 && !rd_op) |-> serial_dout == 1'b0)
    else $error("data out driven during a write frame");
  chk_rd_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid [*1] ##0 !s_axi_arready)
    else $error("read answer not one cycle after address");
  cov_commit: cover property (@(posedge aclk) disable iff (!aresetn) storage_we);
  cov_read_frame: cover property (@(posedge aclk) disable iff (!aresetn)
    frame_take && shift.rd);
  cov_short: cover property (@(posedge aclk) disable iff (!aresetn)
    strobe_done && pending && !storage_we);
  cov_bus_rd: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rready && s_axi_rresp == RESP_OKAY);
endmodule

/* prog_model.sv */
// Purpose: behavioural serial programmer on the far side of the port
// Assumes: serial clock stands low outside frames, 6 ns period
// Notes:   a released data line shows the inverse of its last value
`timescale 1ns/1ns
module prog_model (
  // link drive
  output logic                        serial_clk,
  output logic                        serial_din,
  output eeprom_port_pkg::link_pins_t link_pins,
  // read data
  input  wire logic                   serial_dout
);
  import eeprom_port_pkg::*;
  // strobe grounded, mode and window low at start
  initial begin
    serial_clk = 1'b0;
    serial_din = 1'b0;
    link_pins  = '0;
  end
  // mode level, then settle well past the sync delay
  task automatic set_mode(input logic on);
    link_pins.mode_select = on;
    #400;
  endtask
  // whole frame; read byte taken after edges 8..15
  task automatic frame(input logic [1:0] a, input logic r, input logic [4:0] p,
                       input logic [7:0] d, output logic [7:0] q);
    frame_t f;
    f = {d, p, r, a};
    q = 8'h00;
    link_pins.transfer_window = 1'b1;
    #400;
    for (int k = 0; k < 16; k++) begin
      serial_din = f[k];
      #3 serial_clk = 1'b1;
      #3 serial_clk = 1'b0;
      if (k > 6 && k < 15) q[k-7] = serial_dout;
    end
    #400 link_pins.transfer_window = 1'b0;
    serial_din = ~serial_din; // no pull: never leave the last bit standing
    #400;
  endtask
  // programming pulse image, width in ns
  task automatic strobe(input int w);
    link_pins.program_strobe = 1'b1;
    #(w) link_pins.program_strobe = 1'b0;
    #400;
  endtask
endmodule

/* test_eeprom_serial_programming_port.sv */
// Purpose: self-checking bench for the eeprom serial programming port
// Assumes: strobe minimum cut to 20 aclk cycles for a short run
// Notes:   programmer model drives the link; bench is the bus master
`timescale 1ns/1ns
module test_eeprom_serial_programming_port;
  import eeprom_port_pkg::*;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, sclk, sdin, sdout, oe_n, smode;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rdv, exp_store;
  logic [1:0]  bresp, rresp, resp;
  logic [7:0]  q;
  logic [7:0]  pat [4];
  link_pins_t  pins;
  int          bad_count, num_checks;
  eeprom_serial_programming_port #(.STROBE_MIN_CYC(20)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .serial_clk(sclk), .serial_din(sdin), .link_pins(pins), .serial_dout(sdout),
    .serial_dout_oe_n(oe_n), .serial_mode(smode));
  prog_model m (.serial_clk(sclk), .serial_din(sdin), .link_pins(pins), .serial_dout(sdout));
  // 25 MHz bus clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // bus write: both channels offered together, each released when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        resp = bresp;
        bready <= 1'b0;
        return;
      end
    end
    bad_count++;
    wrap_up();
  endtask
  // bus read; a hung slave counts as a mismatch
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rdv = rdata;
        resp = rresp;
        rready <= 1'b0;
        return;
      end
    end
    bad_count++;
    wrap_up();
  endtask
  // reset level driven at once, then n bus clock edges pass
  task automatic drive_reset(input logic lvl, input int n);
    aresetn <= lvl;
    repeat (n) @(posedge aclk);
  endtask
  task automatic t_reset;
    check("serial_mode", 0, smode);
    check("dout_oe_n", 1, oe_n);
    for (int a = 0; a < 16; a += 4) begin
      rd(a[3:0]);
      check("reset_value", (a == 8) ? STORE_RESET : 0, rdv);
    end
    rd(4'h2);
    check("unmapped_resp", RESP_DECERR, resp);
  endtask
  // write and commit every address, then read each back over the link
  task automatic t_program;
    m.set_mode(1'b1);
    check("serial_mode", 1, smode);
    check("dout_oe_n", 0, oe_n);
    for (int a = 0; a < 4; a++) begin
      m.frame(a[1:0], 1'b0, 5'h00, pat[a], q);
      rd(OFS_STATUS);
      check("pending", {a[1:0], 1'b1}, {rdv[5:4], rdv[2]});
      m.strobe(1600);
      exp_store[8*a+:8] = pat[a];
      rd(OFS_STORE);
      check("store", exp_store, rdv);
    end
    rd(OFS_COUNT);
    check("count", 16'h0404, rdv[15:0]);
    for (int a = 0; a < 4; a++) begin
      m.frame(a[1:0], 1'b1, 5'h00, 8'h00, q);
      check("readback", pat[a], q);
    end
  endtask
  // short strobe and lock both refuse; pending word survives for a retry
  task automatic t_short;
    m.frame(2'd0, 1'b0, 5'h00, 8'h0F, q);
    m.strobe(200);
    rd(OFS_STATUS);
    check("short_pend", 2'b11, {rdv[6], rdv[2]});
    wr(OFS_STATUS, 32'h0000_0040, 4'h1);
    rd(OFS_STATUS);
    check("short_w1c", 0, rdv[6]);
    wr(OFS_CTRL, 32'h0000_0001, 4'hE);
    rd(OFS_CTRL);
    check("lock_strb", 0, rdv);
    wr(OFS_CTRL, 32'h0000_0001, 4'hF);
    rd(OFS_CTRL);
    check("lock_set", 1, rdv);
    m.strobe(1600);
    rd(OFS_STORE);
    check("locked", exp_store, rdv);
    wr(OFS_CTRL, 32'h0000_0000, 4'hF);
    m.strobe(1600);
    exp_store[7:0] = 8'h0F;
    rd(OFS_STORE);
    check("retry", exp_store, rdv);
    m.frame(2'd0, 1'b1, 5'h00, 8'h00, q);
    check("readback", 8'h0F, q);
  endtask
  // bad padding, refused bus accesses, frames with mode low
  task automatic t_errors;
    m.frame(2'd1, 1'b1, 5'h15, 8'h00, q);
    rd(OFS_STATUS);
    check("frame_error", 1, rdv[7]);
    wr(4'h1, 32'h0000_0001, 4'hF);
    check("unmapped_wr", RESP_DECERR, resp);
    wr(OFS_STORE, 32'hFFFF_FFFF, 4'hF);
    check("ro_resp", RESP_OKAY, resp);
    m.set_mode(1'b0);
    check("serial_mode", 0, smode);
    check("dout_oe_n", 1, oe_n);
    m.frame(2'd2, 1'b0, 5'h00, 8'h77, q);
    m.strobe(1600);
    rd(OFS_STORE);
    check("mode_off", exp_store, rdv);
  endtask
  // reset for 20 cycles, the scenarios, then a mid-run reset
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    bad_count = 0;
    num_checks = 0;
    exp_store = STORE_RESET;
    pat = '{8'hA5, 8'h3C, 8'h81, 8'h5E};
    drive_reset(1'b0, 20);
    drive_reset(1'b1, 1);
    t_reset();
    t_program();
    t_short();
    t_errors();
    // flags, counters and store are non-zero here, so the reset is seen
    drive_reset(1'b0, 8);
    drive_reset(1'b1, 1);
    t_reset();
    wrap_up();
  end
endmodule
